// File: include/nvc_pkg.sv
// Constants, register map and carrier types for the NVM access block.
// Assumes one 250 MHz clock and a byte-wide register port.
package nvc_pkg;

	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_UNLOCK = 4'h1;
	localparam logic [3:0] OFS_DATA = 4'h2;
	localparam logic [3:0] OFS_ADRL = 4'h3;
	localparam logic [3:0] OFS_ADRH = 4'h4;
	localparam logic [3:0] OFS_LATCH = 4'h5;
	localparam logic [3:0] OFS_IRQ = 4'h6;
	localparam logic [3:0] OFS_PROT = 4'h7;
	localparam logic [3:0] OFS_TPL = 4'h8;
	localparam logic [3:0] OFS_TPH = 4'h9;
	localparam logic [3:0] OFS_TPU = 4'hA;

	localparam int B_RD = 0;
	localparam int B_WR = 1;
	localparam int B_WEN = 2;
	localparam int B_ERR = 3;
	localparam int B_FREE = 4;
	localparam int B_RGN_LO = 6;
	localparam int B_RGN_HI = 7;
	localparam int B_DONE = 0;
	localparam int B_WPROT = 0;

	localparam logic [1:0] RGN_EE = 2'h0;
	localparam logic [1:0] RGN_FLASH = 2'h2;

	localparam logic [7:0] UNLOCK_1 = 8'h55;
	localparam logic [7:0] UNLOCK_2 = 8'hAA;

	localparam logic [21:0] UID_LO = 22'h20_0000;
	localparam logic [21:0] UID_HI = 22'h20_000F;
	localparam logic [21:0] CFG_LO = 22'h30_0000;
	localparam logic [21:0] CFG_HI = 22'h30_0009;
	localparam logic [21:0] INFO_LO = 22'h3F_0000;
	localparam logic [21:0] INFO_HI = 22'h3F_003F;
	localparam logic [21:0] CINFO_LO = 22'h3F_FF00;
	localparam logic [21:0] CINFO_HI = 22'h3F_FF09;
	localparam logic [21:0] ID_LO = 22'h3F_FFFC;
	localparam logic [21:0] ID_HI = 22'h3F_FFFF;
	localparam logic [21:0] FLASH_TOP_DEF = 22'h02_0000;
	localparam logic [4:0] CFG_BASE_IDX = 5'h10;

	localparam int CLK_PERIOD_NS = 4;
	localparam int PROG_TIME_NS = 2000000;
	localparam int PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;

	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic PROT_RST = 1'b1;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} nvc_bus_s;

	typedef enum logic [1:0] {UL_IDLE, UL_HALF, UL_ARMED} nvc_unlock_e;

endpackage

// File: design/nvc_nvm_access.sv
// NVM access controller: control, unlock, data, address and latch logic.
// Assumes a CPU-side register port on clk and async reset-event pins.
module nvc_nvm_access
	import nvc_pkg::*;
#(
	parameter int EE_ADDR_W = 10,
	parameter int PROG_CYCLES = PROG_CYCLES_DEF,
	parameter logic [21:0] FLASH_TOP = FLASH_TOP_DEF,
	parameter logic [7:0] INFO_FILL = 8'h00,
	parameter logic [31:0] DEVICE_ID = 32'h0000_0000
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire nvc_bus_s bus,
	output logic [7:0] rdata,
	input wire logic tbl_rd_req,
	input wire logic ext_pin_reset_req,
	input wire logic watchdog_reset_req,
	output logic cpu_stall,
	output logic mem_op_done_flag
);

	// The value of DEVICE_ID is arbitrary.
	localparam int EE_DEPTH = 1 << EE_ADDR_W;
	localparam int CW = $clog2(PROG_CYCLES + 1);
	localparam logic [CW-1:0] CNT_LOAD = CW'(PROG_CYCLES - 1);
	localparam logic [CW-1:0] CNT_ZERO = '0;

	logic [1:0] region_reg;
	logic erase_en_reg;
	logic write_error_flag;
	logic write_enable_bit;
	logic write_start_reg;
	logic read_start_reg;
	logic [7:0] eeprom_data_reg;
	logic [7:0] eeprom_addr_low_reg;
	logic [7:0] eeprom_addr_high_reg;
	logic [7:0] table_latch_reg;
	logic [21:0] table_pointer;
	logic config_write_protect;
	logic done_reg;
	logic stall_reg;
	logic [7:0] rdata_reg;
	logic [CW-1:0] cnt_reg;
	nvc_unlock_e ul_state;
	logic [7:0] ee_mem [0:EE_DEPTH-1];
	logic [7:0] spec_mem [0:31];
	logic [2:0] pin_sync_reg;
	logic [2:0] watchdog_sync_reg;

	logic ctrl_wr;
	logic [1:0] rgn_new;
	logic [15:0] ee_addr_full;
	logic ee_ok;
	logic spec_wr_ok;
	logic spec_rd_ok;
	logic [7:0] spec_rdata;
	logic [4:0] spec_idx;
	logic tgt_ok;
	logic start_try;
	logic start_now;
	logic wr_end;
	logic abort;
	logic [7:0] rmux;

	function automatic logic in_rng(input logic [21:0] a,
		input logic [21:0] lo, input logic [21:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction

	////////////////////////////////////////////////////////////////////
	// Reset-event pins are asynchronous, so each passes two flops first.

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pin_sync_reg <= '0;
			watchdog_sync_reg <= '0;
		end else begin
			pin_sync_reg <= {pin_sync_reg[1:0], ext_pin_reset_req};
			watchdog_sync_reg <= {watchdog_sync_reg[1:0],
				watchdog_reset_req};
		end
	end

	assign abort = (pin_sync_reg[1] & ~pin_sync_reg[2]) |
		(watchdog_sync_reg[1] & ~watchdog_sync_reg[2]);

	////////////////////////////////////////////////////////////////////
	// Target decode.

	assign ctrl_wr = bus.wr && (bus.addr == OFS_CTRL);
	assign rgn_new = bus.wdata[B_RGN_HI:B_RGN_LO];
	assign ee_addr_full = {eeprom_addr_high_reg, eeprom_addr_low_reg};
	assign ee_ok = (ee_addr_full >> EE_ADDR_W) == 16'h0000;
	assign spec_wr_ok = in_rng(table_pointer, UID_LO, UID_HI) ||
		in_rng(table_pointer, CFG_LO, CFG_HI);
	assign spec_idx = in_rng(table_pointer, UID_LO, UID_HI) ?
		table_pointer[4:0] : CFG_BASE_IDX + table_pointer[4:0];
	assign spec_rd_ok = spec_wr_ok ||
		in_rng(table_pointer, INFO_LO, INFO_HI) ||
		in_rng(table_pointer, CINFO_LO, CINFO_HI) ||
		in_rng(table_pointer, ID_LO, ID_HI);

	always_comb begin
		spec_rdata = BYTE_ZERO;
		if (spec_wr_ok) begin
			spec_rdata = spec_mem[spec_idx];
		end else if (in_rng(table_pointer, ID_LO, ID_HI)) begin
			spec_rdata = DEVICE_ID[8*table_pointer[1:0] +: 8];
		end else if (spec_rd_ok) begin
			spec_rdata = INFO_FILL;
		end
	end

	// A mismatch of region and address reads as an invalid target.
	always_comb begin
		if (rgn_new[0]) begin
			tgt_ok = spec_wr_ok && config_write_protect;
		end else if (rgn_new == RGN_FLASH) begin
			tgt_ok = table_pointer < FLASH_TOP;
		end else begin
			tgt_ok = ee_ok;
		end
	end

	assign start_try = ctrl_wr && !write_start_reg && bus.wdata[B_WR] &&
		write_enable_bit && (ul_state == UL_ARMED);
	assign start_now = start_try && tgt_ok;
	assign wr_end = write_start_reg && (cnt_reg == CNT_ZERO) && !abort;

	////////////////////////////////////////////////////////////////////
	// Control register. While a write runs it is frozen.

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			region_reg <= RGN_EE;
			erase_en_reg <= 1'b0;
			write_enable_bit <= 1'b0;
			write_start_reg <= 1'b0;
			read_start_reg <= 1'b0;
			write_error_flag <= 1'b0;
		end else begin
			read_start_reg <= 1'b0;
			if (abort && write_start_reg) begin
				write_start_reg <= 1'b0;
			end else if (wr_end) begin
				write_start_reg <= 1'b0;
				write_error_flag <= 1'b0;
			end
			if (ctrl_wr && !write_start_reg) begin
				region_reg <= rgn_new;
				erase_en_reg <= bus.wdata[B_FREE];
				write_enable_bit <= bus.wdata[B_WEN];
				write_error_flag <= bus.wdata[B_ERR];
				if (bus.wdata[B_RD] && rgn_new != RGN_FLASH) begin
					read_start_reg <= 1'b1;
				end
				if (start_now) begin
					write_start_reg <= 1'b1;
					write_error_flag <= 1'b1;
				end else if (start_try) begin
					write_error_flag <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Unlock detector.

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ul_state <= UL_IDLE;
		end else if (start_try || abort) begin
			ul_state <= UL_IDLE;
		end else if (bus.wr && bus.addr == OFS_UNLOCK) begin
			case (ul_state)
				UL_HALF: begin
					ul_state <= (bus.wdata == UNLOCK_2) ? UL_ARMED :
						(bus.wdata == UNLOCK_1) ? UL_HALF : UL_IDLE;
				end
				default: begin
					ul_state <= (bus.wdata == UNLOCK_1) ? UL_HALF : UL_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Programming timer sets the write time, not software.

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_reg <= CNT_ZERO;
		end else if (start_now) begin
			cnt_reg <= CNT_LOAD;
		end else if (write_start_reg && cnt_reg != CNT_ZERO) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Data, address, pointer, latch and protect registers.

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			eeprom_data_reg <= BYTE_ZERO;
			eeprom_addr_low_reg <= BYTE_ZERO;
			eeprom_addr_high_reg <= BYTE_ZERO;
		end else if (read_start_reg && region_reg == RGN_EE) begin
			eeprom_data_reg <= ee_ok ? ee_mem[ee_addr_full[EE_ADDR_W-1:0]] :
				BYTE_ZERO;
		end else if (bus.wr && !write_start_reg) begin
			if (bus.addr == OFS_DATA) begin
				eeprom_data_reg <= bus.wdata;
			end
			if (bus.addr == OFS_ADRL) begin
				eeprom_addr_low_reg <= bus.wdata;
			end
			if (bus.addr == OFS_ADRH) begin
				eeprom_addr_high_reg <= bus.wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			table_pointer <= '0;
			config_write_protect <= PROT_RST;
		end else if (bus.wr && !write_start_reg) begin
			if (bus.addr == OFS_TPL) begin
				table_pointer[7:0] <= bus.wdata;
			end
			if (bus.addr == OFS_TPH) begin
				table_pointer[15:8] <= bus.wdata;
			end
			if (bus.addr == OFS_TPU) begin
				table_pointer[21:16] <= bus.wdata[5:0];
			end
			if (bus.addr == OFS_PROT) begin
				config_write_protect <= bus.wdata[B_WPROT];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			table_latch_reg <= BYTE_ZERO;
		end else if (tbl_rd_req && region_reg[0]) begin
			table_latch_reg <= spec_rdata;
		end else if (bus.wr && bus.addr == OFS_LATCH) begin
			table_latch_reg <= bus.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Array updates. Flash rows live outside this block, so a flash
	// erase or write only runs the timer here.

	always_ff @(posedge clk) begin
		if (wr_end && region_reg == RGN_EE) begin
			ee_mem[ee_addr_full[EE_ADDR_W-1:0]] <= eeprom_data_reg;
		end
		if (wr_end && region_reg[0]) begin
			spec_mem[spec_idx] <= table_latch_reg;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Done flag, stall and read port.

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			done_reg <= 1'b0;
		end else if (wr_end) begin
			done_reg <= 1'b1;
		end else if (bus.wr && bus.addr == OFS_IRQ && !bus.wdata[B_DONE]) begin
			done_reg <= 1'b0;
		end
	end

	// EEPROM writes let the CPU run on; other writes and table reads while region_reg[0] is set stall it.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			stall_reg <= 1'b0;
		end else begin
			stall_reg <= (start_now && rgn_new != RGN_EE) ||
				(write_start_reg && !wr_end && !abort &&
				region_reg != RGN_EE) ||
				(tbl_rd_req && region_reg[0]);
		end
	end

	always_comb begin
		case (bus.addr)
			OFS_CTRL: rmux = {region_reg, 1'b0, erase_en_reg,
				write_error_flag, write_enable_bit, write_start_reg,
				read_start_reg};
			OFS_DATA: rmux = eeprom_data_reg;
			OFS_ADRL: rmux = eeprom_addr_low_reg;
			OFS_ADRH: rmux = eeprom_addr_high_reg;
			OFS_LATCH: rmux = table_latch_reg;
			OFS_IRQ: rmux = {7'h00, done_reg};
			OFS_PROT: rmux = {7'h00, config_write_protect};
			OFS_TPL: rmux = table_pointer[7:0];
			OFS_TPH: rmux = table_pointer[15:8];
			OFS_TPU: rmux = {2'h0, table_pointer[21:16]};
			default: rmux = BYTE_ZERO;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdata_reg <= BYTE_ZERO;
		end else begin
			rdata_reg <= bus.rd ? rmux : BYTE_ZERO;
		end
	end

	assign rdata = rdata_reg;
	assign cpu_stall = stall_reg;
	assign mem_op_done_flag = done_reg;

	////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_start;
		start_now;
	endsequence

	sequence s_bad_start;
		start_try && !tgt_ok;
	endsequence

	a_write_enable_bit_gate: assert property ($rose(write_start_reg) |->
		$past(write_enable_bit) && $past(ul_state) == UL_ARMED)
		else $error("Write started without enable or unlock.");
	a_start_err: assert property (s_start |=> write_error_flag &&
		write_start_reg) else $error("Start did not set error flag.");
	a_bad_start: assert property (s_bad_start |=>
		write_error_flag && !write_start_reg)
		else $error("Refused start did not flag error.");
	a_abort_err: assert property (abort && write_start_reg |=>
		!write_start_reg && write_error_flag && !$rose(done_reg))
		else $error("Aborted write not reported.");
	a_done_end: assert property (wr_end |=> !write_start_reg &&
		!write_error_flag && done_reg) else $error("Bad completion.");
	a_wr_hold: assert property (write_start_reg && !wr_end && !abort
		|=> write_start_reg) else $error("Write start dropped early.");
	a_write_enable_bit_keep: assert property (!ctrl_wr |=> $stable(write_enable_bit))
		else $error("Write enable changed by hardware.");
	a_rd_flash: assert property (read_start_reg |->
		region_reg != RGN_FLASH) else $error("Read start in flash.");
	a_latch_zero: assert property (tbl_rd_req && region_reg[0] &&
		!spec_rd_ok && !bus.wr |=> table_latch_reg == BYTE_ZERO)
		else $error("Invalid table read left latch nonzero.");
	a_unlock_rearm: assert property (s_start |=> ul_state == UL_IDLE
		##1 ul_state != UL_ARMED) else $error("Unlock not re-armed.");
	a_flag_hold: assert property (done_reg && !(bus.wr && bus.addr ==
		OFS_IRQ) |=> done_reg) else $error("Done flag lost.");

endmodule

// File: sim/nvc_nvm_access_bench.sv
// Self-checking bench for the NVM access block, driven at its ports.
// Assumes the package is compiled first and a short programming count.
module nvc_nvm_access_bench
	import nvc_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	// Long enough that a few bus cycles fit inside one write.
	localparam int PC = 16;

	logic clk;
	logic rst_b;
	logic tbl_rd_req;
	logic ext_pin_reset_req;
	logic watchdog_reset_req;
	nvc_bus_s bus;
	logic [7:0] rdata;
	logic cpu_stall;
	logic mem_op_done_flag;
	int n_mismatch = 0;
	int compares = 0;

	nvc_nvm_access #(.PROG_CYCLES(PC)) nvc_nvm_access_inst (
		.clk(clk),
		.rst_b(rst_b),
		.bus(bus),
		.rdata(rdata),
		.tbl_rd_req(tbl_rd_req),
		.ext_pin_reset_req(ext_pin_reset_req),
		.watchdog_reset_req(watchdog_reset_req),
		.cpu_stall(cpu_stall),
		.mem_op_done_flag(mem_op_done_flag)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task summarize;
		if (n_mismatch == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task chk1(input string n, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %b seen %b", n, e, g);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask

	task rdchk(input string n, input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		#1;
		chk8(n, e, rdata);
	endtask

	task unlock;
		wr(OFS_UNLOCK, UNLOCK_1);
		wr(OFS_UNLOCK, UNLOCK_2);
	endtask

	task start(input logic [7:0] c);
		wr(OFS_CTRL, c);
		unlock();
		wr(OFS_CTRL, c | 8'h02);
	endtask

	task wait_done;
		for (int i = 0; i < PC + 4 && mem_op_done_flag !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		chk1("done", 1'b1, mem_op_done_flag);
	endtask

	task set_tp(input logic [21:0] p);
		wr(OFS_TPL, p[7:0]);
		wr(OFS_TPH, p[15:8]);
		wr(OFS_TPU, {2'b00, p[21:16]});
	endtask

	task table_read_instr(input logic s);
		@(posedge clk);
		tbl_rd_req <= 1'b1;
		@(posedge clk);
		tbl_rd_req <= 1'b0;
		#1;
		chk1("stall_tbl", s, cpu_stall);
		@(posedge clk);
		#1;
		chk1("stall_after", 1'b0, cpu_stall);
	endtask

	////////////////////////////////////////////////////////////////////////
	task t_reset;
		rdchk("ctrl", OFS_CTRL, 8'h00);
		rdchk("prot", OFS_PROT, 8'h01);
		rdchk("unlock", OFS_UNLOCK, 8'h00);
		rdchk("unmapped", 4'hB, 8'h00);
	endtask

	task t_gate;
		unlock();
		wr(OFS_CTRL, 8'h02);
		rdchk("ctrl", OFS_CTRL, 8'h00);
		// A stray value throws away the armed state.
		wr(OFS_UNLOCK, 8'h12);
		wr(OFS_CTRL, 8'h04);
		wr(OFS_CTRL, 8'h06);
		rdchk("ctrl", OFS_CTRL, 8'h04);
		wr(OFS_UNLOCK, UNLOCK_1);
		wr(OFS_UNLOCK, 8'h12);
		wr(OFS_UNLOCK, UNLOCK_2);
		wr(OFS_CTRL, 8'h06);
		rdchk("ctrl", OFS_CTRL, 8'h04);
	endtask

	task t_ee;
		wr(OFS_ADRL, 8'h3C);
		wr(OFS_ADRH, 8'h03);
		wr(OFS_DATA, 8'h5A);
		start(8'h04);
		rdchk("ctrl", OFS_CTRL, 8'h0E);
		chk1("stall", 1'b0, cpu_stall);
		wr(OFS_CTRL, 8'h00);
		wr(OFS_DATA, 8'h00);
		rdchk("ctrl", OFS_CTRL, 8'h0E);
		wait_done();
		rdchk("ctrl", OFS_CTRL, 8'h04);
		rdchk("data", OFS_DATA, 8'h5A);
		wr(OFS_DATA, 8'h00);
		wr(OFS_CTRL, 8'h05);
		rdchk("data", OFS_DATA, 8'h5A);
		chk1("done", 1'b1, mem_op_done_flag);
		wr(OFS_IRQ, 8'h00);
		#1;
		chk1("done", 1'b0, mem_op_done_flag);
		wr(OFS_ADRH, 8'h04);
		start(8'h04);
		rdchk("ctrl", OFS_CTRL, 8'h0C);
		chk1("done", 1'b0, mem_op_done_flag);
		wr(OFS_ADRH, 8'h03);
	endtask

	task t_abort;
		for (int k = 0; k < 2; k++) begin
			// A finished write would leave C3h, so 5Ah proves the abort.
			wr(OFS_DATA, 8'hC3);
			start(8'h04);
			@(posedge clk);
			if (k == 0) ext_pin_reset_req <= 1'b1;
			else watchdog_reset_req <= 1'b1;
			repeat (PC + 4) @(posedge clk);
			ext_pin_reset_req <= 1'b0;
			watchdog_reset_req <= 1'b0;
			rdchk("ctrl", OFS_CTRL, 8'h0C);
			chk1("done", 1'b0, mem_op_done_flag);
			wr(OFS_CTRL, 8'h05);
			rdchk("data", OFS_DATA, 8'h5A);
		end
	endtask

	task t_special;
		set_tp(UID_LO + 22'h3);
		wr(OFS_LATCH, 8'hA7);
		start(8'h44);
		@(posedge clk);
		#1;
		chk1("stall", 1'b1, cpu_stall);
		wait_done();
		rdchk("ctrl", OFS_CTRL, 8'h44);
		wr(OFS_LATCH, 8'h00);
		table_read_instr(1'b1);
		rdchk("latch", OFS_LATCH, 8'hA7);
		wr(OFS_IRQ, 8'h00);
		set_tp(CFG_HI);
		wr(OFS_LATCH, 8'h3C);
		start(8'hC4);
		wait_done();
		wr(OFS_LATCH, 8'h00);
		table_read_instr(1'b1);
		rdchk("latch", OFS_LATCH, 8'h3C);
		set_tp(22'h25_0000);
		table_read_instr(1'b1);
		rdchk("latch", OFS_LATCH, 8'h00);
		set_tp(INFO_LO);
		start(8'hC4);
		rdchk("ctrl", OFS_CTRL, 8'hCC);
		wr(OFS_PROT, 8'h00);
		set_tp(CFG_LO);
		start(8'hC4);
		rdchk("ctrl", OFS_CTRL, 8'hCC);
		wr(OFS_PROT, 8'h01);
		// With EEPROM selected a table read neither stalls nor loads.
		wr(OFS_CTRL, 8'h04);
		wr(OFS_LATCH, 8'h11);
		table_read_instr(1'b0);
		rdchk("latch", OFS_LATCH, 8'h11);
	endtask

	task t_flash;
		wr(OFS_IRQ, 8'h00);
		set_tp(22'h00_1000);
		wr(OFS_CTRL, 8'h85);
		rdchk("ctrl", OFS_CTRL, 8'h84);
		start(8'h94);
		rdchk("ctrl", OFS_CTRL, 8'h9E);
		chk1("stall", 1'b1, cpu_stall);
		wait_done();
		rdchk("ctrl", OFS_CTRL, 8'h94);
		wr(OFS_CTRL, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		summarize();
	end

	initial begin
		bus = '0;
		tbl_rd_req = 1'b0;
		ext_pin_reset_req = 1'b0;
		watchdog_reset_req = 1'b0;
		rst_b = 1'b0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		chk1("stall_rst", 1'b0, cpu_stall);
		chk1("done_rst", 1'b0, mem_op_done_flag);
		t_reset();
		t_gate();
		t_ee();
		t_abort();
		t_special();
		t_flash();
		summarize();
	end
endmodule
